// >>> rtl/rsq_pkg.sv
// Package of constants, types and register layout for the rail sequencer
package rsq_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int RAIL_N     = 12;
  localparam int FIELD_N    = 10;
  localparam int DW         = 16;
  localparam int AW         = 8;
  localparam int VW         = 12;
  localparam int TW         = 12;
  localparam int INT_W      = 4;
  localparam int LOG_DEPTH  = 12;
  localparam int LOG_PW     = 4;
  localparam int STAMP_W    = 10;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ       = 20_000_000;
  localparam int TICK_TIME_MS = 1;
  localparam int TICK_CYCLES  = CLK_HZ / 1000 * TICK_TIME_MS;
  localparam int TICK_W       = 15;
  localparam logic [TW-1:0] TMR_MAX = 12'hFFF;

  // ---------------------------------------------------------------------------
  // Register map: addr[7:4] selects rail or global page, addr[3:0] the field
  // ---------------------------------------------------------------------------
  localparam logic [3:0] F_PG_ON    = 4'h0;
  localparam logic [3:0] F_PG_OFF   = 4'h1;
  localparam logic [3:0] F_UV_FLT   = 4'h2;
  localparam logic [3:0] F_UV_WRN   = 4'h3;
  localparam logic [3:0] F_OV_WRN   = 4'h4;
  localparam logic [3:0] F_OV_FLT   = 4'h5;
  localparam logic [3:0] F_TON_DLY  = 4'h6;
  localparam logic [3:0] F_TOFF_DLY = 4'h7;
  localparam logic [3:0] F_TON_MAX  = 4'h8;
  localparam logic [3:0] F_CTL      = 4'h9;
  localparam logic [3:0] F_DEP      = 4'hA;
  localparam logic [3:0] F_STATUS   = 4'hB;
  localparam logic [3:0] PAGE_GLB   = 4'hF;
  localparam logic [3:0] G_OPERATION = 4'h0;
  localparam logic [3:0] G_INT_STAT  = 4'h1;
  localparam logic [3:0] G_INT_MASK  = 4'h2;
  localparam logic [3:0] G_NV_CTRL   = 4'h3;
  localparam logic [3:0] G_LOG_IDX   = 4'h4;
  localparam logic [3:0] G_LOG_DATA  = 4'h5;

  // ---------------------------------------------------------------------------
  // Bit positions and reset values
  // ---------------------------------------------------------------------------
  localparam int OP_ON_BIT    = 0;
  localparam int OP_FAST_BIT  = 1;
  localparam int INT_FAULT    = 0;
  localparam int INT_WARN     = 1;
  localparam int INT_NV_DONE  = 2;
  localparam int INT_LOG_FULL = 3;
  localparam int NVC_STORE    = 0;
  localparam int NVC_RESTORE  = 1;
  localparam int NVC_CLR_LOG  = 2;
  localparam logic [1:0]       OPERATION_RST = 2'h0;
  localparam logic [INT_W-1:0] INT_MASK_RST  = 4'h0;
  localparam logic [DW-1:0]    CFG_RST       = 16'h0000;
  localparam logic [DW-1:0]    NV_SIG        = 16'hA5C3;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {ST_OFF, ST_ON_DLY, ST_RAMP, ST_REG, ST_OFF_DLY, ST_FALL} rsq_state_e;
  typedef enum logic [1:0] {NV_IDLE, NV_STORE, NV_RESTORE} rsq_nv_e;
  typedef enum logic [1:0] {RESP_RESTART, RESP_SHUTDOWN, RESP_SEQ_OFF, RESP_GROUP} rsq_resp_e;
  typedef enum logic [1:0] {FT_UV, FT_OV, FT_TON, FT_TOFF} rsq_ftype_e;

  typedef struct packed {
    logic [3:0] rsv;
    logic       margin_req;
    logic       has_margin;
    logic       has_en;
    logic       has_mon;
    logic [1:0] resp_ton;
    logic [1:0] resp_ov;
    logic [1:0] resp_uv;
    logic       pin_ctl;
    logic       op_ctl;
  } rsq_ctl_s;

  typedef struct packed {
    logic [3:0] rsv_hi;
    logic [3:0] faults;
    logic [1:0] rsv_lo;
    logic       ov_warn;
    logic       uv_warn;
    logic       power_good;
    rsq_state_e state;
  } rsq_stat_s;

  typedef struct packed {
    logic [3:0]         rail;
    rsq_ftype_e         ftype;
    logic [STAMP_W-1:0] stamp;
  } rsq_log_s;

endpackage : rsq_pkg

// >>> rtl/rsq_top.sv
// Twelve-rail power sequencer with fault monitor, fault log and config store
// Notes on behaviour
// - Up to twelve rails, each switched by its own enable output.
// - Sequence-on starts from the control pin or the operation command.
// - Pin-controlled rails turn on and off with the control pin.
// - Regulated rails compared against UV and OV warning and fault limits.
// - Faults restart, shut down, sequence off, or group shutdown and restart.
// - UV, OV and turn-on time faults each have their own response selection per rail.
// - Working configuration copied to nonvolatile store, restored after reset.
// - Per-rail status kept; faults logged into nonvolatile storage.
// - Management bus runs at standard 100 kHz or fast 400 kHz.
// - Alert signal tells the host that attention is needed.
// - Rail consists of monitor, enable and margin output; one needed.
// - Each rail has dependent rails turned off when it faults.
// - Maximum time to reach good-on or good-off, else fault flagged.
// - Rail on above good-on limit, regulated until below good-off.
// - Max turn-on time in ms steps; zero disables the limit.
module rsq_top
  import rsq_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic [AW-1:0]               addr_i,
  input  wire logic [DW-1:0]               wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [DW-1:0]               rdata_o,
  input  wire logic                        host_sequence_control_pin_i,
  input  wire logic [RAIL_N-1:0][VW-1:0]   rail_voltage_i,
  output logic      [RAIL_N-1:0]           rail_enable_o,
  output logic      [RAIL_N-1:0]           rail_margin_o,
  output logic                             irq_o,
  output logic                             smbus_alert_o,
  output logic                             smbus_alert_oe_o,
  output logic                             bus_fast_mode_o
);

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic [DW-1:0]       cfg_r [RAIL_N][FIELD_N+1];
  logic [DW-1:0]       nv_mem [RAIL_N][FIELD_N+1];
  logic [DW-1:0]       nv_sig_r;
  rsq_log_s            log_mem [LOG_DEPTH];
  logic [LOG_PW-1:0]   log_cnt_r;

  logic [1:0]          pin_sync_r;
  logic [1:0]          op_r;
  logic [TICK_W-1:0]   tick_cnt_r;
  logic                tick_r;
  logic [STAMP_W-1:0]  stamp_r;
  logic [INT_W-1:0]    int_st_r;
  logic [INT_W-1:0]    int_mask_r;
  logic [INT_W-1:0]    int_nxt;
  logic [LOG_PW-1:0]   log_idx_r;
  rsq_nv_e             nv_st_r;
  logic                boot_r;
  logic [3:0]          nv_rail_r;
  logic [3:0]          nv_fld_r;
  logic                nv_done;
  logic [DW-1:0]       rdata_r;
  logic                irq_r;
  logic [RAIL_N-1:0]   margin_r;
  logic [RAIL_N-1:0]   warn_prev_r;

  logic [RAIL_N-1:0]          flt_vec;
  logic [RAIL_N-1:0]          grp_vec;
  logic [RAIL_N-1:0]          evt_vec;
  logic [RAIL_N-1:0]          warn_vec;
  logic [RAIL_N-1:0]          en_vec;
  logic [RAIL_N-1:0]          mrg_vec;
  rsq_ftype_e                 evt_type [RAIL_N];
  logic [RAIL_N-1:0][DW-1:0]  stat_vec;
  logic [RAIL_N-1:0][RAIL_N-1:0] dep_mx;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  wire [3:0] page      = addr_i[7:4];
  wire [3:0] fld       = addr_i[3:0];
  wire       page_rail = page < 4'(RAIL_N);
  wire       page_glb  = page == PAGE_GLB;
  wire       nv_idle   = nv_st_r == NV_IDLE;
  wire       cfg_wr    = wr_i && page_rail && fld <= F_DEP && nv_idle;
  wire       stat_wr   = wr_i && page_rail && fld == F_STATUS;
  wire       glb_wr    = wr_i && page_glb;
  wire       nvc_wr    = glb_wr && fld == G_NV_CTRL && nv_idle;
  wire       pin_s     = pin_sync_r[1];
  wire       nv_last   = nv_rail_r == 4'(RAIL_N - 1) && nv_fld_r == F_DEP;
  wire       evt_any   = |evt_vec;
  wire       log_full  = log_cnt_r == LOG_PW'(LOG_DEPTH);

  // ---------------------------------------------------------------------------
  // Pin synchroniser and millisecond tick
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_sync_r <= 2'b00;
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
      stamp_r    <= '0;
    end else begin
      pin_sync_r <= {pin_sync_r[0], host_sequence_control_pin_i};
      tick_r     <= tick_cnt_r == TICK_W'(TICK_CYCLES_P - 1);
      tick_cnt_r <= (tick_cnt_r == TICK_W'(TICK_CYCLES_P - 1)) ? '0 : tick_cnt_r + 1'b1;
      if (tick_r) stamp_r <= stamp_r + 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Rail controllers
  // ---------------------------------------------------------------------------
  for (genvar g = 0; g < RAIL_N; g++) begin : g_rail
    rsq_ctl_s      ctl;
    rsq_state_e    st_r;
    rsq_ftype_e    ftype;
    rsq_resp_e     resp;
    logic [TW-1:0] tmr_r;
    logic [3:0]    flt_r;
    logic [3:0]    flt_set;
    logic [VW-1:0] v;
    logic          en_r;
    logic          latch_r;
    logic          slv;
    logic          slv_latch;
    logic          ton_hit;
    logic          toff_hit;
    logic          pg_on_ok;
    logic          uv_f;
    logic          ov_f;
    logic          flt_now;

    assign ctl   = rsq_ctl_s'(cfg_r[g][F_CTL]);
    assign v     = rail_voltage_i[g];
    wire cmd_on  = (ctl.op_ctl && op_r[OP_ON_BIT]) || (ctl.pin_ctl && pin_s);
    wire defined = ctl.has_mon || ctl.has_en || ctl.has_margin;
    wire [TW-1:0] tmax = cfg_r[g][F_TON_MAX][TW-1:0];
    wire max_on  = tmax != '0;
    wire ge_max  = tmr_r >= tmax;
    wire in_reg  = st_r == ST_REG && ctl.has_mon;
    wire uv_w    = in_reg && v < cfg_r[g][F_UV_WRN][VW-1:0];
    wire ov_w    = in_reg && v > cfg_r[g][F_OV_WRN][VW-1:0];

    // Unmonitored rail counts as good once its max time has run
    assign pg_on_ok = ctl.has_mon ? v >= cfg_r[g][F_PG_ON][VW-1:0] : ge_max;
    assign ton_hit  = st_r == ST_RAMP && ctl.has_mon && max_on && ge_max && !pg_on_ok;
    assign toff_hit = st_r == ST_FALL && ctl.has_mon && max_on && ge_max;
    assign uv_f     = in_reg && (v < cfg_r[g][F_UV_FLT][VW-1:0] ||
                                 v < cfg_r[g][F_PG_OFF][VW-1:0]);
    assign ov_f     = in_reg && v > cfg_r[g][F_OV_FLT][VW-1:0];
    assign flt_now  = ton_hit || uv_f || ov_f;
    assign ftype    = ton_hit ? FT_TON : (ov_f ? FT_OV : FT_UV);
    assign resp     = rsq_resp_e'(ton_hit ? ctl.resp_ton :
                                  (ov_f ? ctl.resp_ov : ctl.resp_uv));
    assign flt_set  = ({3'b000, flt_now} << ftype) | {toff_hit, 3'b000};

    always_comb begin
      slv       = 1'b0;
      slv_latch = 1'b0;
      for (int m = 0; m < RAIL_N; m++) begin
        if (flt_vec[m] && dep_mx[m][g]) begin
          slv = 1'b1;
          if (!grp_vec[m]) slv_latch = 1'b1;
        end
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        st_r    <= ST_OFF;
        tmr_r   <= '0;
        en_r    <= 1'b0;
        latch_r <= 1'b0;
      end else begin
        if (!cmd_on) latch_r <= 1'b0;
        if (tick_r && tmr_r != TMR_MAX) tmr_r <= tmr_r + 1'b1;
        unique case (st_r)
          ST_OFF: if (cmd_on && !latch_r && defined) begin
            st_r  <= ST_ON_DLY;
            tmr_r <= '0;
          end
          ST_ON_DLY: if (!cmd_on || slv) begin
            st_r    <= ST_OFF;
            latch_r <= slv && slv_latch;
          end else if (tmr_r >= cfg_r[g][F_TON_DLY][TW-1:0]) begin
            en_r  <= ctl.has_en;
            st_r  <= ST_RAMP;
            tmr_r <= '0;
          end
          ST_RAMP, ST_REG: if (flt_now) begin
            unique case (resp)
              RESP_RESTART:  begin en_r <= 1'b0; st_r <= ST_OFF; latch_r <= 1'b0; end
              RESP_SHUTDOWN: begin en_r <= 1'b0; st_r <= ST_OFF; latch_r <= 1'b1; end
              RESP_SEQ_OFF:  begin st_r <= ST_OFF_DLY; tmr_r <= '0; latch_r <= 1'b1; end
              RESP_GROUP:    begin en_r <= 1'b0; st_r <= ST_OFF; latch_r <= 1'b0; end
            endcase
          end else if (!cmd_on || slv) begin
            st_r    <= ST_OFF_DLY;
            tmr_r   <= '0;
            latch_r <= slv && slv_latch;
          end else if (st_r == ST_RAMP && pg_on_ok) begin
            st_r <= ST_REG;
          end
          ST_OFF_DLY: if (tmr_r >= cfg_r[g][F_TOFF_DLY][TW-1:0]) begin
            en_r  <= 1'b0;
            st_r  <= ST_FALL;
            tmr_r <= '0;
          end
          ST_FALL: if (!ctl.has_mon || v < cfg_r[g][F_PG_OFF][VW-1:0] || toff_hit) begin
            st_r <= ST_OFF;
          end
          default: st_r <= ST_OFF;
        endcase
      end
    end

    // Set beats a same-cycle write-one clear
    always_ff @(posedge clk_i) begin
      if (rst_i) flt_r <= 4'h0;
      else       flt_r <= (flt_r & ~((stat_wr && page == 4'(g)) ? wdata_i[11:8] : 4'h0))
                          | flt_set;
    end

    assign flt_vec[g]  = flt_now;
    assign grp_vec[g]  = resp == RESP_GROUP;
    assign evt_vec[g]  = flt_now || toff_hit;
    assign evt_type[g] = toff_hit ? FT_TOFF : ftype;
    assign warn_vec[g] = uv_w || ov_w;
    assign en_vec[g]   = en_r;
    assign mrg_vec[g]  = ctl.has_margin && ctl.margin_req;
    assign dep_mx[g]   = cfg_r[g][F_DEP][RAIL_N-1:0];
    assign stat_vec[g] = rsq_stat_s'{rsv_hi: 4'h0, faults: flt_r, rsv_lo: 2'b00,
                                     ov_warn: ov_w, uv_warn: uv_w,
                                     power_good: st_r == ST_REG, state: st_r};
  end

  // ---------------------------------------------------------------------------
  // Working configuration and nonvolatile copy engine
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int r = 0; r < RAIL_N; r++)
        for (int f = 0; f <= FIELD_N; f++) cfg_r[r][f] <= CFG_RST;
      nv_st_r   <= NV_IDLE;
      boot_r    <= 1'b1;
      nv_rail_r <= '0;
      nv_fld_r  <= '0;
    end else begin
      if (cfg_wr) cfg_r[page][fld] <= wdata_i;
      if (nv_st_r != NV_IDLE) begin
        nv_fld_r <= (nv_fld_r == F_DEP) ? 4'h0 : nv_fld_r + 1'b1;
        if (nv_fld_r == F_DEP) nv_rail_r <= nv_rail_r + 1'b1;
        if (nv_last) nv_st_r <= NV_IDLE;
      end
      if (nv_st_r == NV_RESTORE) cfg_r[nv_rail_r][nv_fld_r] <= nv_mem[nv_rail_r][nv_fld_r];
      if (nv_idle) begin
        nv_rail_r <= '0;
        nv_fld_r  <= '0;
        boot_r    <= 1'b0;
        // Stale or blank store is never loaded
        if (boot_r && nv_sig_r == NV_SIG)                 nv_st_r <= NV_RESTORE;
        else if (nvc_wr && wdata_i[NVC_STORE])            nv_st_r <= NV_STORE;
        else if (nvc_wr && wdata_i[NVC_RESTORE] && nv_sig_r == NV_SIG) nv_st_r <= NV_RESTORE;
      end
    end
  end

  assign nv_done = nv_st_r != NV_IDLE && nv_last;

  // Nonvolatile arrays keep their contents through reset
  always_ff @(posedge clk_i) begin
    if (nv_st_r == NV_STORE) nv_mem[nv_rail_r][nv_fld_r] <= cfg_r[nv_rail_r][nv_fld_r];
    if (nv_st_r == NV_STORE && nv_last) nv_sig_r <= NV_SIG;
    if (nvc_wr && wdata_i[NVC_CLR_LOG]) begin
      log_cnt_r <= '0;
    end else if (evt_any && !log_full) begin
      log_cnt_r <= log_cnt_r + 1'b1;
      for (int r = RAIL_N - 1; r >= 0; r--) begin
        if (evt_vec[r]) log_mem[log_cnt_r] <= '{rail: 4'(r), ftype: evt_type[r], stamp: stamp_r};
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Global registers, interrupt and alert
  // ---------------------------------------------------------------------------
  wire [INT_W-1:0] int_clr = (glb_wr && fld == G_INT_STAT) ? wdata_i[INT_W-1:0] : '0;
  wire [INT_W-1:0] int_set = {evt_any && log_full, nv_done,
                              |(warn_vec & ~warn_prev_r), evt_any};
  assign int_nxt = (int_st_r & ~int_clr) | int_set;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_r        <= OPERATION_RST;
      int_st_r    <= '0;
      int_mask_r  <= INT_MASK_RST;
      log_idx_r   <= '0;
      warn_prev_r <= '0;
      irq_r       <= 1'b0;
      margin_r    <= '0;
    end else begin
      if (glb_wr && fld == G_OPERATION) op_r <= wdata_i[1:0];
      if (glb_wr && fld == G_INT_MASK)  int_mask_r <= wdata_i[INT_W-1:0];
      if (glb_wr && fld == G_LOG_IDX)   log_idx_r <= wdata_i[LOG_PW-1:0];
      int_st_r    <= int_nxt;
      warn_prev_r <= warn_vec;
      irq_r       <= |(int_nxt & int_mask_r);
      margin_r    <= mrg_vec;
    end
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  wire [DW-1:0] log_word = (log_idx_r < log_cnt_r) ? DW'(log_mem[log_idx_r]) : '0;
  wire [DW-1:0] glb_word =
      (fld == G_OPERATION) ? {14'h0000, op_r} :
      (fld == G_INT_STAT)  ? {12'h000, int_st_r} :
      (fld == G_INT_MASK)  ? {12'h000, int_mask_r} :
      (fld == G_NV_CTRL)   ? {7'h00, nv_sig_r == NV_SIG, 3'h0, !nv_idle, log_cnt_r} :
      (fld == G_LOG_IDX)   ? {12'h000, log_idx_r} :
      (fld == G_LOG_DATA)  ? log_word : '0;
  wire [DW-1:0] rail_word = (fld <= F_DEP)     ? cfg_r[page][fld] :
                            (fld == F_STATUS)  ? stat_vec[page] : '0;
  wire [DW-1:0] rd_mux = page_rail ? rail_word : (page_glb ? glb_word : '0);

  always_ff @(posedge clk_i) begin
    if (rst_i) rdata_r <= '0;
    else       rdata_r <= rd_i ? rd_mux : '0;
  end

  assign rdata_o          = rdata_r;
  assign rail_enable_o    = en_vec;
  assign rail_margin_o    = margin_r;
  assign irq_o            = irq_r;
  assign smbus_alert_o    = 1'b0;
  assign smbus_alert_oe_o = irq_r;
  assign bus_fast_mode_o  = op_r[OP_FAST_BIT];

endmodule // rsq_top

// >>> tb/rsq_checker.sv
// Port assertions for the rail sequencer
module rsq_checker
  import rsq_pkg::*;
(
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic          wr_i,
  input wire logic          rd_i,
  input wire logic [DW-1:0] rdata_o,
  input wire logic          irq_o,
  input wire logic          smbus_alert_o,
  input wire logic          smbus_alert_oe_o,
  input wire logic          bus_fast_mode_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---
  // Decodes and sequences
  // ---
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic cfg_f = addr_i[7:4] < 4'hC && addr_i[3:0] <= 4'h8;
  wire logic hole  = (addr_i[7:4] < 4'hC && addr_i[3:0] > 4'hB)
                     || (addr_i[7:4] == 4'hF && addr_i[3:0] > 4'h5);
  wire logic no_pg = addr_i[7:4] inside {4'hC, 4'hD, 4'hE};
  sequence s_wr_rd;
    wr_i && cfg_f ##1 !wr_i && !rd_i ##1 rd_i && addr_i == $past(addr_i, 2);
  endsequence
  sequence s_mask0;
    wr_i && addr_i == 8'hF2 && wdata_i[3:0] == 4'h0 ##1 !(wr_i && addr_i == 8'hF2);
  endsequence
  sequence s_op;
    wr_i && addr_i == 8'hF0 ##1 !(wr_i && addr_i == 8'hF0);
  endsequence
  // ---
  // Properties
  // ---
  AST_READBACK: assert property (s_wr_rd |=> rdata_o == $past(wdata_i, 3))
    else $error("config readback wrong");
  AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data outside read cycle");
  AST_HOLE: assert property (rd_i && hole |=> rdata_o == 16'h0000)
    else $error("unmapped field read nonzero");
  AST_NO_PAGE: assert property (rd_i && no_pg |=> rdata_o == 16'h0000)
    else $error("page beyond twelve rails read nonzero");
  AST_FAST: assert property (s_op |=> bus_fast_mode_o == $past(wdata_i[1], 2))
    else $error("bus rate bit not taken");
  AST_MASK: assert property (s_mask0 |=> !irq_o)
    else $error("masked interrupt still high");
  AST_ALERT_OE: assert property (smbus_alert_oe_o == irq_o)
    else $error("alert pull differs from interrupt");
  AST_ALERT_LO: assert property (smbus_alert_oe_o |-> !smbus_alert_o)
    else $error("alert driven high");
endmodule // rsq_checker

bind rsq_top rsq_checker u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .smbus_alert_o(smbus_alert_o),
  .smbus_alert_oe_o(smbus_alert_oe_o), .bus_fast_mode_o(bus_fast_mode_o));

// >>> tb/rsq_supply_model.sv
// Supplies switched by the enables, with a stuck-low fault input
module rsq_supply_model
  import rsq_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic [RAIL_N-1:0]         en_i,
  input  wire logic [RAIL_N-1:0]         drop_i,
  output logic      [RAIL_N-1:0][VW-1:0] volt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---
  // Ramp
  // ---
  // Coarse slew keeps ramps short, yet crossing takes many cycles
  always_ff @(posedge clk_i) begin
    for (int g = 0; g < RAIL_N; g++) begin
      if (rst_i) volt_o[g] <= '0;
      else if (drop_i[g]) volt_o[g] <= 12'h100;
      else if (en_i[g] && volt_o[g] < 12'hA00) volt_o[g] <= volt_o[g] + 12'h040;
      else if (!en_i[g] && volt_o[g] >= 12'h040) volt_o[g] <= volt_o[g] - 12'h040;
    end
  end
endmodule // rsq_supply_model

// >>> tb/tb.sv
// Self-checking bench of the rail sequencer
module tb
  import rsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ---
  // Signals
  // ---
  localparam int TK = 20;
  logic                      clk_i = 1'b0;
  logic                      rst_i = 1'b1;
  logic                      wr_i = 1'b0;
  logic                      rd_i = 1'b0;
  logic                      pin = 1'b0;
  logic [AW-1:0]             addr_i = '0;
  logic [DW-1:0]             wdata_i = '0;
  logic [DW-1:0]             rdata_o;
  logic [DW-1:0]             d;
  logic [RAIL_N-1:0]         en;
  logic [RAIL_N-1:0]         mrg;
  logic [RAIL_N-1:0]         drop = '0;
  logic [RAIL_N-1:0][VW-1:0] volt;
  logic                      irq;
  logic                      fast;
  int                        num_errors = 0;
  int                        tests_run = 0;
  int                        s, n, i;
  logic [7:0]                hl[3] = '{8'hE0, 8'h0C, 8'hF9};
  logic [15:0]               cv[10] = '{16'h0800, 16'h0400, 16'h0300, 16'h0500,
    16'h0C00, 16'h0E00, 16'h0002, 16'h0002, 16'h0005, 16'h0F05};
  rsq_top #(.TICK_CYCLES_P(TK)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .host_sequence_control_pin_i(pin),
    .rail_voltage_i(volt), .rail_enable_o(en), .rail_margin_o(mrg), .irq_o(irq),
    .smbus_alert_o(), .smbus_alert_oe_o(), .bus_fast_mode_o(fast));
  rsq_supply_model u_sup (.clk_i(clk_i), .rst_i(rst_i), .en_i(en), .drop_i(drop), .volt_o(volt));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // ---
  // Tasks
  // ---
  task automatic summarize();
    $display("errors %0d of checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, e, m);
    tests_run++;
    if ((got & m) !== (e & m)) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got & m, e & m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rq(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, m);
    rq(a);
    chk(rdata_o, e, m);
  endtask
  // Bounded polling, a spent bound ends the run
  task automatic poll(input logic [7:0] a, input logic [15:0] e, m);
    int k;
    for (k = 0; k < 150; k++) begin
      rq(a);
      if ((rdata_o & m) === (e & m)) break;
    end
    chk(rdata_o, e, m);
    if (k == 150) summarize();
  endtask
  task automatic wt(input logic v, output int c);
    c = 0;
    while (en[s] !== v && c < 300) begin
      @(negedge clk_i);
      c++;
    end
    chk({15'h0, en[s]}, {15'h0, v}, 16'h0001);
    if (c >= 300) summarize();
  endtask
  // ---
  // Scenarios
  // ---
  initial begin
    i = $urandom(33367);
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wr(8'hF3, 16'h0004);
    s = $urandom_range(11);
    for (i = 0; i < 9; i++) begin
      d = 16'($urandom);
      wr({4'((s + 1) % 12), 4'(i)}, d);
      rd({4'((s + 1) % 12), 4'(i)}, d, 16'hFFFF);
    end
    for (i = 0; i < 10; i++) wr({4'(s), 4'(i)}, cv[i]);
    rd({4'(s), 4'h9}, 16'h0F05, 16'hFFFF);
    chk({15'h0, mrg[s]}, 16'h0001, 16'h0001);
    wr(8'hF2, 16'h0001);
    wr(8'hF0, 16'h0001);
    wt(1'b1, n);
    chk(16'(n >= TK && n <= 2 * TK + 8), 16'h0001, 16'h0001);
    poll({4'(s), 4'hB}, 16'h000B, 16'h000F);
    @(posedge clk_i);
    drop[s] <= 1'b1;
    wt(1'b0, n);
    chk(16'(n), 16'h0000, 16'hFFF8);
    poll({4'(s), 4'hB}, 16'h0100, 16'h0F00);
    rd(8'hF1, 16'h0001, 16'h0001);
    chk({15'h0, irq}, 16'h0001, 16'h0001);
    wr(8'hF2, 16'h0000);
    rd(8'hF2, 16'h0000, 16'hFFFF);
    chk({15'h0, irq}, 16'h0000, 16'h0001);
    wr(8'hF4, 16'h0000);
    rd(8'hF5, {4'(s), 12'h000}, 16'hFC00);
    wr(8'hF2, 16'h0001);
    wr(8'hF1, 16'h000F);
    wr({4'(s), 4'hB}, 16'h0F00);
    rd(8'hF1, 16'h0000, 16'h0001);
    chk({15'h0, irq}, 16'h0000, 16'h0001);
    @(posedge clk_i);
    drop[s] <= 1'b0;
    wr(8'hF0, 16'h0000);
    wr({4'(s), 4'h9}, 16'h0F06);
    @(posedge clk_i);
    pin <= 1'b1;
    wt(1'b1, n);
    chk(16'(n >= TK && n <= 2 * TK + 8), 16'h0001, 16'h0001);
    poll({4'(s), 4'hB}, 16'h000B, 16'h000F);
    @(posedge clk_i);
    pin <= 1'b0;
    wt(1'b0, n);
    chk(16'(n >= TK && n <= 2 * TK + 8), 16'h0001, 16'h0001);
    poll({4'(s), 4'hB}, 16'h0000, 16'h0007);
    wr(8'hF0, 16'h0002);
    @(posedge clk_i);
    @(negedge clk_i);
    chk({15'h0, fast}, 16'h0001, 16'h0001);
    wr(8'hF3, 16'h0001);
    poll(8'hF3, 16'h0100, 16'h0110);
    wr({4'(s), 4'h0}, 16'h0123);
    wr(8'hF3, 16'h0002);
    poll(8'hF3, 16'h0100, 16'h0110);
    rd({4'(s), 4'h0}, 16'h0800, 16'hFFFF);
    foreach (hl[i]) rd(hl[i], 16'h0000, 16'hFFFF);
    @(posedge clk_i);
    drop[s] <= 1'b1;
    pin <= 1'b1;
    poll({4'(s), 4'hB}, 16'h0400, 16'h0400);
    summarize();
  end
endmodule // tb
